/* File: bench/tb_tcf_timer.sv */
// tb_tcf_timer: self-checking bench for the timer compare and flag block.
// assumes the block answers each APB access within a few cycles.
`timescale 1ns/10ps
module tb_tcf_timer;
  import tcf_pkg::*;
  logic        clock;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        sel;
  logic        perio;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        err;
  logic [3:0]  cap;
  logic [4:0]  port;
  logic [4:0]  owned;
  logic [7:0]  paddr;
  logic [7:0]  hi;
  logic [15:0] v;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  int          fail_count;
  int          total_checks;
  int          cycles;

  tcf_timer tcf_timer_inst (
    .i_clock              (clock),
    .i_rst                (rst),
    .i_clock_enable       (1'b1),
    .i_psel               (psel),
    .i_penable            (penable),
    .i_pwrite             (pwrite),
    .i_paddr              (paddr),
    .i_pwdata             (pwdata),
    .i_capture_edge       (cap),
    .i_shared_select      (sel),
    .i_periodic_event     (perio),
    .i_event_counter_wrap (1'b0),
    .i_event_input        (1'b0),
    .i_normal_mode        (1'b1),
    .o_pready             (pready),
    .o_prdata             (prdata),
    .o_pslverr            (pslverr),
    .o_port_a             (port),
    .o_pin_owned          (owned),
    .o_irq                (irq)
  );

  always #4 clock = ~clock;

  task automatic conclude;
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard: the full run needs roughly 66k cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic irqchk(input logic exp);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic pulse(input logic [3:0] c, input logic p);
    @(posedge clock);
    cap   <= c;
    perio <= p;
    @(posedge clock);
    cap   <= 4'h0;
    perio <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic t_regs;
    // first prescale write lands inside the post-reset window and locks it
    apb(1'b1, ADR_MASK2, 32'h0);
    for (int i = 0; i < 5; i++) rdchk(ADR_CMP_BASE + 8'(i) * ADR_STEP, 32'hFFFF);
    rdchk(ADR_FORCE, 32'h0);
    apb(1'b1, ADR_PIN_MASK, 32'hFF);
    rdchk(ADR_PIN_MASK, 32'hF8);
    apb(1'b1, ADR_PIN_DATA, 32'hFF);
    rdchk(ADR_PIN_DATA, 32'hF8);
    apb(1'b1, ADR_MASK2, 32'hFF);
    rdchk(ADR_MASK2, 32'hF0);
    apb(1'b1, ADR_MASK2, 32'h0);
    rdchk(ADR_FLAGS1, 32'h0);
    rdchk(ADR_FLAGS2, 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    check({31'h0, err}, 32'h1);
    rdchk(8'h40, 32'h0);
  endtask

  task automatic t_count;
    // transfers are three cycles apart, prescale divides by one
    apb(1'b0, ADR_COUNT, 32'h0);
    v = rd[15:0];
    rdchk(ADR_COUNT, {16'h0, v + 16'd3});
    apb(1'b0, ADR_COUNT_HI, 32'h0);
    hi = rd[7:0];
    apb(1'b0, ADR_COUNT_LO, 32'h0);
    check({16'h0, hi, rd[7:0]}, {16'h0, v + 16'd6});
  endtask

  task automatic t_force;
    apb(1'b1, ADR_PIN_MASK, 32'hF8);
    apb(1'b1, ADR_PIN_DATA, 32'hA8);
    check({27'h0, port}, 32'h0);
    apb(1'b1, ADR_FORCE, 32'h80);
    repeat (2) @(posedge clock);
    check({27'h0, port}, 32'h15);
    rdchk(ADR_FLAGS1, 32'h0);
    apb(1'b1, ADR_PIN_MASK, 32'h0);
  endtask

  task automatic t_compare;
    // channel two drives high, channel three toggles
    apb(1'b1, ADR_ACTION, 32'hD0);
    apb(1'b1, ADR_MASK1, 32'h40);
    apb(1'b0, ADR_COUNT, 32'h0);
    v = rd[15:0] + 16'd30;
    apb(1'b1, ADR_CMP_BASE + ADR_STEP, {16'h0, v});
    apb(1'b1, ADR_CMP_BASE + 8'h08, {16'h0, v});
    repeat (40) @(posedge clock);
    check({27'h0, port}, 32'h19);
    check({27'h0, owned}, 32'h0C);
    irqchk(1'b1);
    rdchk(ADR_FLAGS1, 32'h60);
    apb(1'b1, ADR_FLAGS1, 32'h0);
    rdchk(ADR_FLAGS1, 32'h60);
    apb(1'b1, ADR_FLAGS1, 32'hFF);
    irqchk(1'b0);
    rdchk(ADR_FLAGS1, 32'h0);
  endtask

  task automatic t_wrap;
    // one full counter period: wrap plus the all-ones compares
    repeat (65536) @(posedge clock);
    check({27'h0, port}, 32'h1D);
    rdchk(ADR_FLAGS1, 32'hF8);
    rdchk(ADR_FLAGS2, 32'h80);
    apb(1'b1, ADR_MASK1, 32'h0);
    irqchk(1'b0);
    apb(1'b1, ADR_MASK2, 32'h80);
    irqchk(1'b1);
    apb(1'b1, ADR_MASK2, 32'h0);
    apb(1'b1, ADR_FLAGS1, 32'hFF);
    apb(1'b1, ADR_FLAGS2, 32'hFF);
    irqchk(1'b0);
  endtask

  task automatic t_events;
    pulse(4'b0001, 1'b1);
    rdchk(ADR_FLAGS1, 32'h04);
    rdchk(ADR_FLAGS2, 32'h40);
    apb(1'b1, ADR_MASK2, 32'h40);
    irqchk(1'b1);
    apb(1'b1, ADR_FLAGS2, 32'h40);
    rdchk(ADR_FLAGS2, 32'h0);
    irqchk(1'b0);
    @(posedge clock);
    sel <= 1'b1;
    pulse(4'b1000, 1'b0);
    rdchk(ADR_FLAGS1, 32'h0C);
    apb(1'b1, ADR_MASK1, 32'h08);
    irqchk(1'b1);
  endtask

  task automatic t_prescale;
    // a second reset reopens the prescale window; divide by four
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    apb(1'b1, ADR_MASK2, 32'h1);
    apb(1'b1, ADR_MASK2, 32'h2);
    rdchk(ADR_MASK2, 32'h1);
    apb(1'b0, ADR_COUNT, 32'h0);
    v = rd[15:0];
    repeat (37) @(posedge clock);
    rdchk(ADR_COUNT, {16'h0, v + 16'd10});
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cap = 4'h0;
    perio = 1'b0;
    sel = 1'b0;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_count();
    t_force();
    t_compare();
    t_wrap();
    t_events();
    t_prescale();
    conclude();
  end
endmodule // tb_tcf_timer

/* File: common/tcf_pkg.sv */
// tcf_pkg: register map, reset values and field positions of the timer
// compare and flag block; assumes a 32-bit APB slave decoding paddr[7:0].
package tcf_pkg;
  localparam logic [7:0]  ADR_FORCE    = 8'h00;
  localparam logic [7:0]  ADR_PIN_MASK = 8'h04;
  localparam logic [7:0]  ADR_PIN_DATA = 8'h08;
  localparam logic [7:0]  ADR_COUNT    = 8'h0C;
  localparam logic [7:0]  ADR_COUNT_HI = 8'h10;
  localparam logic [7:0]  ADR_COUNT_LO = 8'h14;
  localparam logic [7:0]  ADR_CMP_BASE = 8'h18;
  localparam logic [7:0]  ADR_ACTION   = 8'h2C;
  localparam logic [7:0]  ADR_MASK1    = 8'h30;
  localparam logic [7:0]  ADR_FLAGS1   = 8'h34;
  localparam logic [7:0]  ADR_MASK2    = 8'h38;
  localparam logic [7:0]  ADR_FLAGS2   = 8'h3C;
  localparam logic [7:0]  ADR_STEP     = 8'h04;
  localparam logic [15:0] CMP_RESET    = 16'hFFFF;
  localparam logic [15:0] COUNT_TOP    = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [6:0]  PRESCALE_WINDOW = 7'h40;
  localparam int          FL1_SHARED   = 3;
  localparam int          FL2_OVERFLOW = 3;
  typedef enum logic [1:0] {
    ACT_OFF    = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_LOW    = 2'b10,
    ACT_HIGH   = 2'b11
  } tcf_action_type;
endpackage

/* File: rtl/tcf_timer.sv */
// tcf_timer: free-running counter, five compare channels driving port A
// bits 7..3, forced compares, flag and mask registers, APB slave.
// assumes capture and event inputs are one-cycle pulses on i_clock.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
// How it works
// - force bit does the channel's pin action like a match, no flag set
// - forced actions happen at the next counter transition after the write
// - low three bits of force, pin mask, pin data read zero
// - channel one pin mask bits 7..3 pick port A pins 7..3
// - channel one match copies data bits onto masked pins
// - counter read only; high byte read latches low byte for next read
// - mode/level pairs: off, toggle, low, high for channels 2..5
// - channel five works only while shared select is clear
// - interrupt raised when an enabled flag is set
// - shared mask bit follows shared select function
// - first mask bits align with first flag bits
// - flags clear only by writing one to them
// - compare flags 1..4 set on each counter match
// - shared flag set by capture four or compare five per select
// - capture flags 1..3 set on detected active edges
// - overflow enable gates overflow flag onto interrupt
// - overflow flag set when counter wraps from all ones to zero
// - prescale written once within 64 cycles of reset in normal mode
// - prescale code divides by 1, 4, 8 or 16
// - second mask bits 3..2 and second flag bits 3..0 read zero
// - second mask upper bits align with second flag upper bits
// - pin action taken on every match even with flag still set
// - compare write blocks that channel's match for one cycle
// - compares checked in the cycle after each count change; compare registers reset all ones
// - periodic flag in bit 6 of second flags
module tcf_timer (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_clock_enable,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_capture_edge,
  input  wire logic        i_shared_select,
  input  wire logic        i_periodic_event,
  input  wire logic        i_event_counter_wrap,
  input  wire logic        i_event_input,
  input  wire logic        i_normal_mode,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic [4:0]       o_port_a,
  output logic [4:0]       o_pin_owned,
  output logic             o_irq
);
  import tcf_pkg::*;

  logic [4:0]  force_pend;
  logic [4:0]  pin_mask;
  logic [4:0]  pin_data;
  logic [15:0] count;
  logic [7:0]  low_buf;
  logic        buf_valid;
  logic [15:0] cmp [0:4];
  logic [4:0]  inhibit;
  logic [7:0]  act_ctl;
  logic [7:0]  mask1;
  logic [7:0]  flags1;
  logic [3:0]  mask2_en;
  logic [1:0]  prescale;
  logic        pr_locked;
  logic [6:0]  age;
  logic [3:0]  flags2;
  logic [3:0]  div;
  logic        fresh;

  function automatic logic act_out(input tcf_action_type a, input logic cur);
    case (a)
      ACT_TOGGLE: act_out = ~cur;
      ACT_LOW:    act_out = 1'b0;
      ACT_HIGH:   act_out = 1'b1;
      default:    act_out = cur;
    endcase
  endfunction

  // apb decode
  wire setup   = i_psel & ~i_penable;
  wire done    = i_psel & i_penable & o_pready;
  wire wr      = done & i_pwrite;
  wire rd_hi   = setup & ~i_pwrite & (i_paddr == ADR_COUNT_HI);
  wire we_force = wr & (i_paddr == ADR_FORCE);
  wire we_pmask = wr & (i_paddr == ADR_PIN_MASK);
  wire we_pdata = wr & (i_paddr == ADR_PIN_DATA);
  wire we_act   = wr & (i_paddr == ADR_ACTION);
  wire we_mask1 = wr & (i_paddr == ADR_MASK1);
  wire we_flg1  = wr & (i_paddr == ADR_FLAGS1);
  wire we_mask2 = wr & (i_paddr == ADR_MASK2);
  wire we_flg2  = wr & (i_paddr == ADR_FLAGS2);
  wire [4:0] we_cmp;

  // prescaled tick
  wire [3:0] div_mask = (prescale == 2'b00) ? 4'h0 :
                        (prescale == 2'b01) ? 4'h3 :
                        (prescale == 2'b10) ? 4'h7 : 4'hF;
  wire tick = ((div & div_mask) == div_mask);
  wire wrap = tick & (count == COUNT_TOP);
  // a write late in the window still counts; once taken the field locks
  wire pr_open = ~i_normal_mode | (~pr_locked & (age < PRESCALE_WINDOW));

  wire [4:0] ch_allowed = {~i_shared_select, 4'hF};
  wire [4:0] match;
  wire [4:0] force_fire = force_pend & {5{tick}} & ch_allowed;
  wire [4:0] ev = match | force_fire;

  // compare channels: index 0 is channel one
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_cmp
      assign we_cmp[g] = wr & (i_paddr == ADR_CMP_BASE + ADR_STEP * 8'(g));
      // only the cycle after a count change may match, once per value
      assign match[g] = fresh & (cmp[g] == count) & ~inhibit[g] & ch_allowed[g];
    end
  endgenerate

  // pin actions of channels two to five on port A bits 6..3
  wire [4:0] pin_oc;
  wire [4:0] own_oc;
  assign pin_oc[4] = o_port_a[4];
  assign own_oc[4] = 1'b0;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      wire tcf_action_type mode = tcf_action_type'(act_ctl[7-2*g -: 2]);
      assign pin_oc[3-g] = ev[g+1] ? act_out(mode, o_port_a[3-g]) : o_port_a[3-g];
      assign own_oc[3-g] = (mode != ACT_OFF) & ch_allowed[g+1];
    end
  endgenerate
  // channel one wins where both touch a pin in one cycle
  wire [4:0] next_port = ev[0] ? ((pin_oc & ~pin_mask) | (pin_data & pin_mask)) : pin_oc;

  wire [7:0] set1 = {match[0], match[1], match[2], match[3],
                     i_shared_select ? i_capture_edge[3] : match[4],
                     i_capture_edge[0], i_capture_edge[1], i_capture_edge[2]};
  wire [3:0] set2 = {wrap, i_periodic_event, i_event_counter_wrap, i_event_input};
  wire [7:0] clr1 = we_flg1 ? i_pwdata[7:0] : 8'h00;
  wire [3:0] clr2 = we_flg2 ? i_pwdata[7:4] : 4'h0;
  wire [7:0] next_flags1 = (flags1 & ~clr1) | set1;
  wire [3:0] next_flags2 = (flags2 & ~clr2) | set2;
  wire next_irq = (|(next_flags1 & mask1)) | (|(next_flags2 & mask2_en));
  // force bits arrive with channel one in bit 7, but index 0 is channel one,
  // so the field is reversed before it is held as pending
  wire [4:0] force_req  = {i_pwdata[3], i_pwdata[4], i_pwdata[5], i_pwdata[6], i_pwdata[7]};
  wire [4:0] next_force = (force_pend & ~{5{tick}}) | (we_force ? force_req : 5'h00);

  // read mux
  logic [31:0] rdata;
  logic        rhit;
  always_comb begin
    rdata = 32'h0000_0000;
    rhit  = 1'b1;
    if (i_paddr == ADR_FORCE) begin
      rdata = 32'h0000_0000;
    end else if (i_paddr == ADR_PIN_MASK) begin
      rdata = {24'h00_0000, pin_mask, 3'h0};
    end else if (i_paddr == ADR_PIN_DATA) begin
      rdata = {24'h00_0000, pin_data, 3'h0};
    end else if (i_paddr == ADR_COUNT) begin
      rdata = {16'h0000, count};
    end else if (i_paddr == ADR_COUNT_HI) begin
      rdata = {24'h00_0000, count[15:8]};
    end else if (i_paddr == ADR_COUNT_LO) begin
      rdata = {24'h00_0000, buf_valid ? low_buf : count[7:0]};
    end else if (i_paddr == ADR_CMP_BASE) begin
      rdata = {16'h0000, cmp[0]};
    end else if (i_paddr == ADR_CMP_BASE + ADR_STEP) begin
      rdata = {16'h0000, cmp[1]};
    end else if (i_paddr == ADR_CMP_BASE + 2 * ADR_STEP) begin
      rdata = {16'h0000, cmp[2]};
    end else if (i_paddr == ADR_CMP_BASE + 3 * ADR_STEP) begin
      rdata = {16'h0000, cmp[3]};
    end else if (i_paddr == ADR_CMP_BASE + 4 * ADR_STEP) begin
      rdata = {16'h0000, cmp[4]};
    end else if (i_paddr == ADR_ACTION) begin
      rdata = {24'h00_0000, act_ctl};
    end else if (i_paddr == ADR_MASK1) begin
      rdata = {24'h00_0000, mask1};
    end else if (i_paddr == ADR_FLAGS1) begin
      rdata = {24'h00_0000, flags1};
    end else if (i_paddr == ADR_MASK2) begin
      rdata = {24'h00_0000, mask2_en, 2'b00, prescale};
    end else if (i_paddr == ADR_FLAGS2) begin
      rdata = {24'h00_0000, flags2, 4'h0};
    end else begin
      rhit = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_clock_enable) begin
      o_pready  <= setup;
      o_prdata  <= (setup & ~i_pwrite) ? rdata : 32'h0000_0000;
      o_pslverr <= setup & ~rhit;
    end
  end

  // counter, prescaler and coherent byte read
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count     <= COUNT_RESET;
      div       <= 4'h0;
      fresh     <= 1'b0;
      age       <= 7'h00;
      prescale  <= 2'b00;
      pr_locked <= 1'b0;
      low_buf   <= 8'h00;
      buf_valid <= 1'b0;
    end else if (i_clock_enable) begin
      div   <= tick ? 4'h0 : div + 4'h1;
      fresh <= tick;
      if (tick) begin
        count <= count + 16'h0001;
      end
      // saturating, so the window never reopens without a reset
      if (age < PRESCALE_WINDOW) begin
        age <= age + 7'h01;
      end
      if (we_mask2 & pr_open) begin
        prescale  <= i_pwdata[1:0];
        pr_locked <= i_normal_mode;
      end
      if (rd_hi) begin
        low_buf   <= count[7:0];
        buf_valid <= 1'b1;
      end else if (done & (i_paddr != ADR_COUNT_HI)) begin
        buf_valid <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      force_pend <= 5'h00;
      pin_mask   <= 5'h00;
      pin_data   <= 5'h00;
      act_ctl    <= 8'h00;
      mask1      <= 8'h00;
      mask2_en   <= 4'h0;
      inhibit    <= 5'h00;
    end else if (i_clock_enable) begin
      force_pend <= next_force;
      inhibit    <= we_cmp;
      if (we_pmask) pin_mask <= i_pwdata[7:3];
      if (we_pdata) pin_data <= i_pwdata[7:3];
      if (we_act)   act_ctl  <= i_pwdata[7:0];
      if (we_mask1) mask1    <= i_pwdata[7:0];
      if (we_mask2) mask2_en <= i_pwdata[7:4];
    end
  end

  generate
    for (g = 0; g < 5; g++) begin : g_cmp_reg
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          cmp[g] <= CMP_RESET;
        end else if (i_clock_enable & we_cmp[g]) begin
          cmp[g] <= i_pwdata[15:0];
        end
      end
    end
  endgenerate

  // flags, pins and interrupt
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flags1      <= 8'h00;
      flags2      <= 4'h0;
      o_port_a    <= 5'h00;
      o_pin_owned <= 5'h00;
      o_irq       <= 1'b0;
    end else if (i_clock_enable) begin
      flags1      <= next_flags1;
      flags2      <= next_flags2;
      o_port_a    <= next_port;
      o_pin_owned <= own_oc | pin_mask;
      o_irq       <= next_irq;
    end
  end

  // checks pause while frozen: a held clock enable would make every
  // one-cycle implication look broken
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst || !i_clock_enable);

  force_pin_a: assert property (force_fire[1] && !ev[0] &&
    act_ctl[7:6] == ACT_HIGH |=> o_port_a[3])
    else $error("forced high action missing");
  force_flag_a: assert property (force_fire[1] && !match[1] && !flags1[6]
    |=> !flags1[6])
    else $error("force set a flag");
  ch1_data_a: assert property (ev[0] && pin_mask[4] |=> o_port_a[4] == $past(pin_data[4]))
    else $error("channel one data not copied");
  match_flag_a: assert property (match[0] |=> flags1[7])
    else $error("match flag not set");
  wrap_flag_a: assert property (wrap |=> count == COUNT_RESET && flags2[FL2_OVERFLOW])
    else $error("overflow flag not set");
  irq_req_a: assert property (flags1[7] && mask1[7] && !clr1[7]
    |=> o_irq)
    else $error("interrupt not raised");
  ovf_irq_a: assert property (flags2[FL2_OVERFLOW] && mask2_en[FL2_OVERFLOW]
    && !clr2[FL2_OVERFLOW] |=> o_irq)
    else $error("overflow interrupt not raised");
  flag_hold_a: assert property (flags1[2] && !clr1[2] |=> flags1[2])
    else $error("flag lost without a clear");
  shared_flag_a: assert property (i_shared_select && i_capture_edge[3]
    |=> flags1[FL1_SHARED])
    else $error("shared capture flag not set");
  count_step_a: assert property (tick |=> count == $past(count) + 16'h0001)
    else $error("counter step wrong");

  pr_lock_a: assert property (pr_locked && i_normal_mode |=> $stable(prescale))
    else $error("prescale changed after lock");
  cmp_inhibit_a: assert property (we_cmp[0] |=> !match[0])
    else $error("match during compare write");
  div_four_a: assert property (prescale == 2'b01 && tick && !we_mask2
    |=> !tick [*3] ##1 tick)
    else $error("divide by four wrong");
  shared_off_a: assert property (i_shared_select |-> !match[4] && !force_fire[4])
    else $error("channel five active in capture mode");

  force_cov: cover property (force_fire[0]);
  wrap_cov: cover property (wrap && mask2_en[FL2_OVERFLOW]);
  shared_cov: cover property (set1[FL1_SHARED] && mask1[FL1_SHARED]);
  div_cov: cover property (prescale == 2'b01 && tick);
  rematch_cov: cover property (match[1] && flags1[6]);

endmodule // tcf_timer
